// [dcsl_pkg.sv]
// dcsl_pkg: shared constants and carrier types for the column shift/latch driver core
// assumes a single hclk domain; every pin is synchronised inside the top module
package dcsl_pkg;
  // geometry of the shift register and latch, and depth of the event queue
  localparam int STAGES    = 96;
  localparam int PINS      = 6;
  localparam int STEP3     = 3;
  localparam int STEP6     = 6;
  localparam int FIFO_DEPTH = 8;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_LATCH0 = 8'h08;
  localparam logic [7:0] OFF_LATCH1 = 8'h0c;
  localparam logic [7:0] OFF_LATCH2 = 8'h10;
  // control register fields
  localparam int CTRL_HOLD_BIT  = 0;
  localparam int CTRL_FLOAT_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // status register fields
  localparam int ST_COUNT_LSB = 0;
  localparam int ST_EMPTY_BIT = 4;
  localparam int ST_FULL_BIT  = 5;
  localparam int ST_OVF_BIT   = 8;
  // one queued pin event: shift and/or latch with the mode seen at that edge
  typedef struct packed {
    logic            shift;
    logic            latch;
    logic            dir;
    logic            wide;
    logic [PINS-1:0] data;
  } dcsl_cmd_t;
  localparam int CMD_W = $bits(dcsl_cmd_t);
  // all slow control and data pins, sampled together
  typedef struct packed {
    logic            xfer_clk;
    logic            latch_strobe_n;
    logic            register_clear_n;
    logic            output_float;
    logic            low_blank_n;
    logic            high_blank_n;
    logic            lane_width_select;
    logic            shift_right;
    logic [PINS-1:0] side_a;
    logic [PINS-1:0] side_b;
  } dcsl_pins_t;
endpackage

// [dcsl_top.sv]
// dcsl_top: shift register, line latch and driver-stage logic of a 96-column driver,
// with an 8-deep event queue between the pins and the shift engine, and an AHB-Lite slave
// assumes the pins are asynchronous to hclk and change much slower than hclk
//
// Notes on behaviour
// - output_float high puts every column output into high impedance, above all else
// - otherwise low_blank_n low drives every column output low
// - otherwise high_blank_n low drives every column output high
// - falling latch_strobe_n copies shift stage n into latch bit n
// - a steady latch strobe keeps latch bits and outputs unchanged
// - stages advance only on a rising transfer clock edge, else hold
// - register_clear_n low forces every shift stage to zero
// - lane_width_select high: three 32-stage lanes fed by three pins
// - lane_width_select low: six 16-stage lanes fed by six pins
// - direction high: side A inputs, side B outputs, shift toward stage 96
// - direction low: side B inputs, side A outputs, shift toward stage 1
// - right shift fills from A and drives the last stages onto side B
// - left shift fills from B and drives the first stages onto side A
// - all lanes shift together in the one selected direction
//
// Implementation choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// event queue
// ----------------------------------------------------------------
module dcsl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         in_valid,
  output logic                              in_ready,
  input  wire logic [WIDTH-1:0]             in_data,
  output logic                              out_valid,
  input  wire logic                         out_ready,
  output logic [WIDTH-1:0]                  out_data,
  output logic [$clog2(DEPTH+1)-1:0]        count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem      [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  // honest full and empty from the count
  assign in_ready  = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // next pointers, count and storage
  always_comb
  begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push)
    begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr      = AW'(wr_ptr + 1'b1);
    end
    if (pop)
      next_rd_ptr = AW'(rd_ptr + 1'b1);
    if (push && !pop)
      next_count = CW'(count + 1'b1);
    else if (pop && !push)
      next_count = CW'(count - 1'b1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
      mem    <= next_mem;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_fifo_count_bound: assert property (count <= CW'(DEPTH))
    else $error("queue count above depth");
endmodule

// ----------------------------------------------------------------
// driver core
// ----------------------------------------------------------------
module dcsl_top (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic [31:0]                    hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  input  wire logic                      xfer_clk,
  input  wire logic                      latch_strobe_n,
  input  wire logic                      register_clear_n,
  input  wire logic                      output_float,
  input  wire logic                      low_blank_n,
  input  wire logic                      high_blank_n,
  input  wire logic                      lane_width_select,
  input  wire logic                      shift_right,
  input  wire logic [dcsl_pkg::PINS-1:0] side_a_data_in,
  output logic [dcsl_pkg::PINS-1:0]      side_a_data_out,
  output logic [dcsl_pkg::PINS-1:0]      side_a_data_oe,
  input  wire logic [dcsl_pkg::PINS-1:0] side_b_data_in,
  output logic [dcsl_pkg::PINS-1:0]      side_b_data_out,
  output logic [dcsl_pkg::PINS-1:0]      side_b_data_oe,
  output logic [dcsl_pkg::STAGES-1:0]    column_outputs,
  output logic [dcsl_pkg::STAGES-1:0]    column_oe
);
  import dcsl_pkg::*;

  dcsl_pins_t        pin_raw;
  dcsl_pins_t        pin_s1;
  dcsl_pins_t        pin_s;
  dcsl_pins_t        pin_d;
  logic [STAGES-1:0] stage;
  logic [STAGES-1:0] next_stage;
  logic [STAGES-1:0] latch_bit;
  logic [STAGES-1:0] next_latch_bit;
  logic [STAGES-1:0] shifted;
  logic [STAGES-1:0] next_col;
  logic [STAGES-1:0] next_col_oe;
  logic [PINS-1:0]   next_a_out;
  logic [PINS-1:0]   next_a_oe;
  logic [PINS-1:0]   next_b_out;
  logic [PINS-1:0]   next_b_oe;
  dcsl_cmd_t         cmd_in;
  dcsl_cmd_t         cmd;
  logic [CMD_W-1:0]  cmd_bits;
  logic              clk_rise;
  logic              le_fall;
  logic              push_valid;
  logic              push_ready;
  logic              pop_valid;
  logic              pop;
  logic [3:0]        fifo_count;
  logic [1:0]        ctrl;
  logic [1:0]        next_ctrl;
  logic              ovf;
  logic              next_ovf;
  logic              float_all;
  logic              dph_valid;
  logic              dph_write;
  logic [7:0]        dph_addr;
  logic              accept;
  logic [31:0]       next_hrdata;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // gather pins into one word
  always_comb
  begin
    pin_raw.xfer_clk          = xfer_clk;
    pin_raw.latch_strobe_n    = latch_strobe_n;
    pin_raw.register_clear_n  = register_clear_n;
    pin_raw.output_float      = output_float;
    pin_raw.low_blank_n       = low_blank_n;
    pin_raw.high_blank_n      = high_blank_n;
    pin_raw.lane_width_select = lane_width_select;
    pin_raw.shift_right       = shift_right;
    pin_raw.side_a            = side_a_data_in;
    pin_raw.side_b            = side_b_data_in;
  end

  // two flops, then one more for edge detection
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_s1 <= '0;
      pin_s  <= '0;
      pin_d  <= '0;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s  <= pin_s1;
      pin_d  <= pin_s;
    end
  end

  assign clk_rise = pin_s.xfer_clk && !pin_d.xfer_clk;
  assign le_fall  = !pin_s.latch_strobe_n && pin_d.latch_strobe_n;

  // ----------------------------------------------------------------
  // event queue between pins and shift engine
  // ----------------------------------------------------------------
  // input side chosen by direction
  always_comb
  begin
    cmd_in.shift = clk_rise;
    cmd_in.latch = le_fall;
    cmd_in.dir   = pin_s.shift_right;
    cmd_in.wide  = pin_s.lane_width_select;
    cmd_in.data  = pin_s.shift_right ? pin_s.side_a : pin_s.side_b;
  end
  // no new shifts queued while clear is held
  assign push_valid = (clk_rise || le_fall) && pin_s.register_clear_n;

  dcsl_fifo #(
    .WIDTH (CMD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (hclk),
    .rst_n     (hresetn),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (cmd_in),
    .out_valid (pop_valid),
    .out_ready (!ctrl[CTRL_HOLD_BIT]),
    .out_data  (cmd_bits),
    .count     (fifo_count)
  );
  assign cmd = dcsl_cmd_t'(cmd_bits);
  assign pop = pop_valid && !ctrl[CTRL_HOLD_BIT];

  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  // every stage moves by the lane count in one direction
  for (genvar i = 0; i < STAGES; i++)
  begin : g_stage
    logic r3;
    logic r6;
    logic l3;
    logic l6;
    if (i < STEP3) assign r3 = cmd.data[i];
    else           assign r3 = stage[i-STEP3];
    if (i < STEP6) assign r6 = cmd.data[i];
    else           assign r6 = stage[i-STEP6];
    if (i >= STAGES-STEP3) assign l3 = cmd.data[i-(STAGES-STEP3)];
    else                   assign l3 = stage[i+STEP3];
    if (i >= STAGES-STEP6) assign l6 = cmd.data[i-(STAGES-STEP6)];
    else                   assign l6 = stage[i+STEP6];
    // right fills from stage 1 side, left from stage 96 side
    assign shifted[i] = cmd.dir ? (cmd.wide ? r3 : r6) : (cmd.wide ? l3 : l6);
  end

  // next stages, latch and cascade pins
  always_comb
  begin
    next_stage     = stage;
    next_latch_bit = latch_bit;
    // latch takes the pre-shift stages on a strobe, else holds
    if (pop && cmd.latch)
      next_latch_bit = stage;
    // shift only on a queued rising edge
    if (pop && cmd.shift)
      next_stage = shifted;
    if (!pin_s.register_clear_n)
      next_stage = '0;
    // cascade outputs, only the pins of live lanes
    for (int k = 0; k < PINS; k++)
    begin
      next_a_out[k] = 1'b0;
      next_b_out[k] = 1'b0;
      next_a_oe[k]  = 1'b0;
      next_b_oe[k]  = 1'b0;
      if (pin_s.lane_width_select ? (k < STEP3) : 1'b1)
      begin
        next_a_oe[k] = !pin_s.shift_right;
        next_b_oe[k] = pin_s.shift_right;
        next_a_out[k] = next_stage[k];
        next_b_out[k] = pin_s.lane_width_select ? next_stage[STAGES-STEP3+k]
                                                : next_stage[STAGES-STEP6+k];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stage           <= '0;
      latch_bit       <= '0;
      side_a_data_out <= '0;
      side_a_data_oe  <= '0;
      side_b_data_out <= '0;
      side_b_data_oe  <= '0;
    end
    else
    begin
      stage           <= next_stage;
      latch_bit       <= next_latch_bit;
      side_a_data_out <= next_a_out;
      side_a_data_oe  <= next_a_oe;
      side_b_data_out <= next_b_out;
      side_b_data_oe  <= next_b_oe;
    end
  end

  // ----------------------------------------------------------------
  // driver stage
  // ----------------------------------------------------------------
  assign float_all = pin_s.output_float || ctrl[CTRL_FLOAT_BIT];

  // priority: float, low blank, high blank, latch data
  always_comb
  begin
    next_col_oe = float_all ? '0 : '1;
    if (float_all || !pin_s.low_blank_n)
      next_col = '0;
    else if (!pin_s.high_blank_n)
      next_col = '1;
    else
      next_col = latch_bit;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      column_outputs <= '0;
      column_oe      <= '0;
    end
    else
    begin
      column_outputs <= next_col;
      column_oe      <= next_col_oe;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  assign accept = hsel && htrans[1] && hready;

  // register writes in data phase, read data at address phase
  always_comb
  begin
    next_ctrl = ctrl;
    next_ovf  = ovf;
    if (dph_valid && dph_write && dph_addr == OFF_CTRL)
      next_ctrl = hwdata[1:0];
    if (dph_valid && dph_write && dph_addr == OFF_STATUS && hwdata[ST_OVF_BIT])
      next_ovf = 1'b0;
    // a lost event sets the flag even in the cycle it is cleared
    if (push_valid && !push_ready)
      next_ovf = 1'b1;
    next_hrdata = '0;
    if (accept && !hwrite)
    begin
      unique case (haddr[7:0])
        OFF_CTRL:   next_hrdata[1:0] = ctrl;
        OFF_STATUS:
        begin
          next_hrdata[ST_COUNT_LSB +: 4] = fifo_count;
          next_hrdata[ST_EMPTY_BIT]      = (fifo_count == 4'h0);
          next_hrdata[ST_FULL_BIT]       = !push_ready;
          next_hrdata[ST_OVF_BIT]        = ovf;
        end
        OFF_LATCH0: next_hrdata = latch_bit[31:0];
        OFF_LATCH1: next_hrdata = latch_bit[63:32];
        OFF_LATCH2: next_hrdata = latch_bit[95:64];
        default:    next_hrdata = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl      <= CTRL_RESET;
      ovf       <= 1'b0;
      dph_valid <= 1'b0;
      dph_write <= 1'b0;
      dph_addr  <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      ctrl      <= next_ctrl;
      ovf       <= next_ovf;
      dph_valid <= accept;
      dph_write <= hwrite;
      dph_addr  <= haddr[7:0];
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_normal;
    !float_all && pin_s.low_blank_n && pin_s.high_blank_n;
  endsequence
  sequence s_shift_pop(d, w);
    pop && cmd.shift && cmd.dir == d && cmd.wide == w && pin_s.register_clear_n;
  endsequence

  a_float_all_z: assert property (float_all |=> column_oe == '0)
    else $error("outputs driven while float requested");
  a_low_blank_out: assert property (!float_all && !pin_s.low_blank_n
    |=> column_outputs == '0 && column_oe == '1)
    else $error("low blank did not drive all low");
  a_high_blank_out: assert property (!float_all && pin_s.low_blank_n && !pin_s.high_blank_n
    |=> column_outputs == '1 && column_oe == '1)
    else $error("high blank did not drive all high");
  a_follow_latch: assert property (s_normal |=> column_outputs == $past(latch_bit))
    else $error("outputs differ from latch");
  a_latch_capture: assert property (pop && cmd.latch |=> latch_bit == $past(stage))
    else $error("latch did not take the stages");
  a_latch_hold: assert property (!(pop && cmd.latch) |=> $stable(latch_bit))
    else $error("latch changed without strobe");
  a_stage_hold: assert property (pin_s.register_clear_n && !(pop && cmd.shift)
    |=> $stable(stage))
    else $error("stages moved without clock edge");
  a_clear_stages: assert property (!pin_s.register_clear_n |=> stage == '0)
    else $error("stages not cleared");
  a_right_three: assert property (s_shift_pop(1'b1, 1'b1)
    |=> stage[2:0] == $past(cmd.data[2:0]) && stage[95:3] == $past(stage[92:0]))
    else $error("three-lane right shift wrong");
  a_left_six: assert property (s_shift_pop(1'b0, 1'b0)
    |=> stage[95:90] == $past(cmd.data) && stage[89:0] == $past(stage[95:6]))
    else $error("six-lane left shift wrong");
  a_left_three: assert property (s_shift_pop(1'b0, 1'b1)
    |=> stage[95:93] == $past(cmd.data[2:0]) && stage[92:0] == $past(stage[95:3]))
    else $error("three-lane left shift wrong");
  a_right_six: assert property (s_shift_pop(1'b1, 1'b0)
    |=> stage[5:0] == $past(cmd.data) && stage[95:6] == $past(stage[89:0]))
    else $error("six-lane right shift wrong");
  // cascade pins in three-lane right mode
  a_cascade_b: assert property (pin_s.shift_right && pin_s.lane_width_select
    |=> side_b_data_oe == 6'h07 && side_a_data_oe == 6'h00
        && side_b_data_out[2:0] == stage[95:93])
    else $error("side B cascade wrong");
  // a rising edge is queued three cycles after the pin settles, one cycle after it is detected
  a_edge_queued: assert property (clk_rise && pin_s.register_clear_n && push_ready
    |=> fifo_count != 4'h0 || $past(pop))
    else $error("rising edge not queued");
endmodule

// [dcsl_ctrl_model.sv]
// dcsl_ctrl_model: display controller that streams pixel bits and strobes the latch
// assumes hclk is the bench clock; every pin changes just after its rising edge
`timescale 1ns/1ps
module dcsl_ctrl_model (
  input  wire logic       hclk,
  input  wire logic       dir,
  input  wire logic       wide,
  input  wire logic [5:0] a_oe,
  input  wire logic [5:0] a_out,
  input  wire logic [5:0] b_oe,
  input  wire logic [5:0] b_out,
  output logic            xfer_clk,
  output logic            latch_strobe_n,
  output logic [5:0]      a_wire,
  output logic [5:0]      b_wire
);
  logic [5:0] drv = 6'h00;
  logic       tog = 1'b0;
  logic [5:0] idle;
  initial xfer_clk = 1'b0;
  initial latch_strobe_n = 1'b1;
  // undriven pins of live lanes change every cycle so a stale value never passes
  always @(posedge hclk) tog <= ~tog;
  assign idle = wide ? {3'h0, {3{tog}}} : {6{tog}};
  // wire level from both parties' enables
  assign a_wire = (a_oe & a_out) | (~a_oe & (dir ? drv : idle));
  assign b_wire = (b_oe & b_out) | (~b_oe & (dir ? idle : drv));
  task automatic shift_bit(input logic [5:0] d);
    @(posedge hclk);
    drv <= wide ? (d & 6'h07) : d;
    repeat (3) @(posedge hclk);
    xfer_clk <= 1'b1;
    repeat (3) @(posedge hclk);
    xfer_clk <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask
  task automatic latch_pulse;
    @(posedge hclk);
    latch_strobe_n <= 1'b0;
    repeat (3) @(posedge hclk);
    latch_strobe_n <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask
endmodule

// [dcsl_tb_top.sv]
// dcsl_tb_top: self-checking bench for the column shift/latch driver core
// assumes dcsl_pkg, dcsl_top.sv and dcsl_ctrl_model.sv are compiled before it
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module dcsl_tb_top;
  import dcsl_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, xclk, strobe_n;
  logic        clr_n = 1'b1, flt = 1'b0, low_blank_n_n = 1'b1, high_blank_n_n = 1'b1, wide = 1'b1, right = 1'b1;
  logic [5:0]  a_w, b_w, a_out, a_oe, b_out, b_oe;
  logic [95:0] cols, cols_oe, exp_sr, old;
  int          mismatches = 0, n_checks = 0;
  // bench clock, 100 ns period
  always #50 hclk = ~hclk;
  dcsl_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .xfer_clk(xclk), .latch_strobe_n(strobe_n),
    .register_clear_n(clr_n), .output_float(flt), .low_blank_n(low_blank_n_n), .high_blank_n(high_blank_n_n),
    .lane_width_select(wide), .shift_right(right), .side_a_data_in(a_w), .side_a_data_out(a_out),
    .side_a_data_oe(a_oe), .side_b_data_in(b_w), .side_b_data_out(b_out), .side_b_data_oe(b_oe),
    .column_outputs(cols), .column_oe(cols_oe));
  dcsl_ctrl_model ctrl (.hclk(hclk), .dir(right), .wide(wide), .a_oe(a_oe), .a_out(a_out),
    .b_oe(b_oe), .b_out(b_out), .xfer_clk(xclk), .latch_strobe_n(strobe_n), .a_wire(a_w), .b_wire(b_w));
  // verdict and end of run
  task automatic wrap_up;
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      i++;
      if (i > 40)
      begin
        mismatches++;
        wrap_up();
      end
      @(posedge hclk);
    end
  endtask
  // one single AHB-Lite word transfer, read data left in rd
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  // read and compare one register
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // one shift through the controller, with the expected register updated
  task automatic sh(input logic [5:0] d);
    int s;
    logic [95:0] v;
    ctrl.shift_bit(d);
    s = wide ? 3 : 6;
    v = wide ? {93'h0, d[2:0]} : {90'h0, d};
    exp_sr = right ? ((exp_sr << s) | v) : ((exp_sr >> s) | (v << (96 - s)));
  endtask
  // a run of shifts with a varying pattern
  task automatic fill(input int n, input logic [5:0] base);
    for (int i = 0; i < n; i++)
      sh(6'(base + 7 * i));
  endtask
  // let pin changes reach the column outputs
  task automatic settle;
    repeat (6) @(posedge hclk);
  endtask
  // strobe the latch and compare the columns
  task automatic latch_chk;
    ctrl.latch_pulse();
    settle();
    `CHK(cols, exp_sr)
    `CHK(cols_oe, '1)
  endtask
  // register map after reset and an unmapped place
  task automatic t_regs;
    `CHK(hresp, 1'b0)
    rd_chk(OFF_CTRL, 32'h0);
    rd_chk(OFF_STATUS, 32'h10);
    rd_chk(8'h40, 32'h0);
  endtask
  // full line, three lanes, rightward, with cascade pins and latch registers
  task automatic t_right3;
    wide <= 1'b1;
    right <= 1'b1;
    fill(32, 6'h05);
    latch_chk();
    `CHK(b_out[2:0], exp_sr[95:93])
    `CHK({a_oe, b_oe}, 12'h007)
    rd_chk(OFF_LATCH0, exp_sr[31:0]);
    rd_chk(OFF_LATCH1, exp_sr[63:32]);
    rd_chk(OFF_LATCH2, exp_sr[95:64]);
  endtask
  // full line, six lanes, leftward
  task automatic t_left6;
    wide <= 1'b0;
    right <= 1'b0;
    fill(16, 6'h2a);
    latch_chk();
    `CHK(a_out, exp_sr[5:0])
    `CHK({a_oe, b_oe}, 12'hfc0)
    `CHK(cols, exp_sr)
  endtask
  // the two remaining pairs: three lanes leftward, six lanes rightward
  task automatic t_mixed;
    wide <= 1'b1;
    right <= 1'b0;
    fill(32, 6'h09);
    latch_chk();
    `CHK(a_out[2:0], exp_sr[2:0])
    `CHK({a_oe, b_oe}, 12'h1c0)
    wide <= 1'b0;
    right <= 1'b1;
    fill(16, 6'h13);
    latch_chk();
    `CHK(b_out, exp_sr[95:90])
    `CHK({a_oe, b_oe}, 12'h03f)
  endtask
  // driver priority, pins then the control register float bit
  task automatic t_driver;
    flt <= 1'b1;
    low_blank_n_n <= 1'b0;
    high_blank_n_n <= 1'b0;
    settle();
    `CHK(cols_oe, '0)
    flt <= 1'b0;
    settle();
    `CHK(cols, '0)
    low_blank_n_n <= 1'b1;
    settle();
    `CHK(cols, '1)
    high_blank_n_n <= 1'b1;
    settle();
    `CHK(cols, exp_sr)
    ahb(1'b1, OFF_CTRL, 32'h2);
    repeat (2) @(posedge hclk);
    `CHK(cols_oe, '0)
    rd_chk(OFF_CTRL, 32'h2);
    ahb(1'b1, OFF_CTRL, 32'h0);
    settle();
  endtask
  // partial line without strobe, then strobe with the clock steady
  task automatic t_hold;
    old = exp_sr;
    fill(5, 6'h11);
    settle();
    `CHK(cols, old)
    settle();
    latch_chk();
  endtask
  // queue held: fill until refused, clear overflow, drain to empty
  task automatic t_queue;
    ahb(1'b1, OFF_CTRL, 32'h1);
    fill(8, 6'h21);
    ctrl.shift_bit(6'h3f);
    rd_chk(OFF_STATUS, 32'h128);
    ahb(1'b1, OFF_STATUS, 32'h100);
    rd_chk(OFF_STATUS, 32'h028);
    ahb(1'b1, OFF_CTRL, 32'h0);
    repeat (20) @(posedge hclk);
    rd_chk(OFF_STATUS, 32'h010);
    latch_chk();
  endtask
  // clear empties every stage and drops edges meanwhile
  task automatic t_clear;
    clr_n <= 1'b0;
    ctrl.shift_bit(6'h3f);
    settle();
    clr_n <= 1'b1;
    settle();
    exp_sr = '0;
    latch_chk();
  endtask
  // main sequence
  initial
  begin
    exp_sr = '0;
    repeat (12) @(posedge hclk);
    `CHK(cols_oe, '0)
    `CHK(a_oe | b_oe, 6'h00)
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_regs();
    t_right3();
    t_left6();
    t_mixed();
    t_driver();
    t_hold();
    t_queue();
    t_clear();
    wrap_up();
  end
  // overall limit on run length
  initial
  begin
    #9000000;
    mismatches++;
    wrap_up();
  end
endmodule
